// File: src/plsr_bank.sv
// Per-port link status register bank of a three-port switch
// Notes on behaviour
// [RQ1] Status zero bits 7,6,5: crossover state, negotiation complete, link good; read-only
// [RQ2] Status zero bit 4: partner pause capability, read-only, zero at reset
// [RQ3] Status zero bits 3..0: partner 100FD, 100HD, 10FD, 10HD abilities
// [RQ4] Third port has no status zero; its slot reads zero
// [RQ5] Status one exists for all three ports at 0x1F, 0x2F, 0x3F
// [RQ6] Status one bit 7 writable crossover algorithm select, default 1, unused on port 3
// [RQ7] Status one bit 6 reserved, reads zero; software leaves it alone
// [RQ8] Status one bit 5 reversed receive polarity, 10 Mb/s only, not on port 3
// [RQ9] Status one bit 4 transmit pause active
// [RQ10] Status one bit 3 receive pause active
// [RQ11] Status one bit 2 resolved speed, 1 means 100 Mb/s
// [RQ12] Status one bit 1 resolved duplex, 1 means full
// [RQ13] Status one bit 0 far-end fault, only on port 1
// [RQ14] Status zero of port 1 at 0x1E, port 2 at 0x2E
// [RQ15] Status fields track live state, reads have no side effects, RO writes ignored
`timescale 1ns/1ps
`default_nettype none
`include "plsr_regs.svh"
module plsr_bank (
    input wire logic core_clk,
    input wire logic resetn,
    input wire plsr_pkg::plsr_req_t req,
    output logic [7:0] rdata,
    output logic rvalid,
    input wire plsr_pkg::plsr_phy_stat_t phy1_stat,
    input wire plsr_pkg::plsr_phy_stat_t phy2_stat,
    input wire plsr_pkg::plsr_link_stat_t link1_stat,
    input wire plsr_pkg::plsr_link_stat_t link2_stat,
    input wire plsr_pkg::plsr_link_stat_t link3_stat,
    output logic [1:0] crossover_algo_select
);
    // ==========================================================
    // Offset decoding
    // Used by the checks only; the write path and the read decode compare the offsets directly
    function automatic logic is_algo_ofs(input logic [7:0] a);
        return (a == `PLSR_P1_STAT1_OFS) || (a == `PLSR_P2_STAT1_OFS);
    endfunction

    // Status one exists for all three ports
    function automatic logic is_stat1_ofs(input logic [7:0] a);
        return is_algo_ofs(a) || (a == `PLSR_P3_STAT1_OFS);
    endfunction

    // The third port's status zero slot counts as mapped: it answers, with zero
    function automatic logic is_stat0_ofs(input logic [7:0] a);
        return (a == `PLSR_P1_STAT0_OFS) || (a == `PLSR_P2_STAT0_OFS) || (a == `PLSR_P3_STAT0_OFS);
    endfunction

    // Anything else on the bus is outside this bank and reads as zero
    function automatic logic is_mapped_ofs(input logic [7:0] a);
        return is_stat0_ofs(a) || is_stat1_ofs(a);
    endfunction

    // ==========================================================
    // Live status capture
    // Inputs are sampled every cycle so reads see state one cycle old; cleared by reset.
    // One flop stage costs a cycle of lag but keeps the read mux off the transceiver wires.
    plsr_pkg::plsr_phy_stat_t ph1_q, ph2_q;
    plsr_pkg::plsr_link_stat_t ln1_q, ln2_q, ln3_q;

    // Negotiation state and partner abilities of the two transceiver ports
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ph1_q <= '0;
            ph2_q <= '0;
        end else begin
            ph1_q <= phy1_stat; // see [RQ1] see [RQ2] see [RQ3] see [RQ15]
            ph2_q <= phy2_stat; // see [RQ15]
        end
    end

    // Resolved speed, duplex, pause and fault state of all three ports
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ln1_q <= '0;
            ln2_q <= '0;
            ln3_q <= '0;
        end else begin
            ln1_q <= link1_stat; // see [RQ9] see [RQ10] see [RQ11] see [RQ12]
            ln2_q <= link2_stat; // see [RQ15]
            ln3_q <= link3_stat; // see [RQ15]
        end
    end

    // ==========================================================
    // Crossover algorithm select
    // Only the transceiver ports hold this bit; a write to port 3 status one changes nothing
    logic [1:0] algo_q;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            algo_q <= {2{`PLSR_ALGO_RESET}}; // see [RQ6]
        end else if (req.wr) begin
            if (req.addr == `PLSR_P1_STAT1_OFS) begin
                algo_q[0] <= req.wdata[`PLSR_S1_ALGO_BIT]; // see [RQ6]
            end else if (req.addr == `PLSR_P2_STAT1_OFS) begin
                algo_q[1] <= req.wdata[`PLSR_S1_ALGO_BIT]; // see [RQ6]
            end
        end
    end
    assign crossover_algo_select = algo_q;

    // ==========================================================
    // Status one assembly
    function automatic logic [7:0] stat1(input logic algo, input plsr_pkg::plsr_link_stat_t s,
                                         input logic pol_ok, input logic fef_ok);
        logic [7:0] v;
        v = `PLSR_ZERO_BYTE;
        v[`PLSR_S1_ALGO_BIT] = algo; // see [RQ6]
        v[`PLSR_S1_RSVD_BIT] = `PLSR_RSVD_VALUE; // see [RQ7]
        // Polarity detection only means something at 10 Mb/s, so it is hidden at 100
        v[`PLSR_S1_POL_BIT] = s.pol_reversed & pol_ok & ~s.speed_100; // see [RQ8]
        v[`PLSR_S1_TXP_BIT] = s.tx_pause_active; // see [RQ9]
        v[`PLSR_S1_RXP_BIT] = s.rx_pause_active; // see [RQ10]
        v[`PLSR_S1_SPD_BIT] = s.speed_100; // see [RQ11]
        v[`PLSR_S1_DUP_BIT] = s.duplex_full; // see [RQ12]
        // Only the first port carries far-end fault; elsewhere the input is ignored
        v[`PLSR_S1_FEF_BIT] = s.far_end_fault & fef_ok; // see [RQ13]
        return v;
    endfunction

    // ==========================================================
    // Read decode
    // Reads are pure: no state changes on any read; unmapped offsets return zero
    logic [7:0] rd_d;
    always_comb begin
        rd_d = `PLSR_ZERO_BYTE;
        if (req.addr == `PLSR_P1_STAT0_OFS) begin
            rd_d = ph1_q; // see [RQ14]
        end else if (req.addr == `PLSR_P2_STAT0_OFS) begin
            rd_d = ph2_q; // see [RQ14]
        end else if (req.addr == `PLSR_P3_STAT0_OFS) begin
            rd_d = `PLSR_ZERO_BYTE; // see [RQ4]
        end else if (req.addr == `PLSR_P1_STAT1_OFS) begin
            rd_d = stat1(algo_q[0], ln1_q, 1'b1, 1'b1); // see [RQ5]
        end else if (req.addr == `PLSR_P2_STAT1_OFS) begin
            // Second transceiver: polarity shown, no far-end fault indication
            rd_d = stat1(algo_q[1], ln2_q, 1'b1, 1'b0); // see [RQ5]
        end else if (req.addr == `PLSR_P3_STAT1_OFS) begin
            // Third port has no transceiver: no algorithm select, polarity or far-end fault
            rd_d = stat1(1'b0, ln3_q, 1'b0, 1'b0); // see [RQ5]
        end
    end

    // Registered read data, valid one cycle after the request
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= `PLSR_ZERO_BYTE;
            rvalid <= 1'b0;
        end else begin
            rvalid <= req.rd;
            if (req.rd) begin
                rdata <= rd_d;
            end
        end
    end

    // ==========================================================
    // Checks
    // Each read is answered at the next edge, so every read check pairs a request with that answer

    // Port 1 status zero returns the captured transceiver state whole
    read_p1s0_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RQ1]
        req.rd && req.addr == `PLSR_P1_STAT0_OFS |=> rdata == $past(ph1_q))
        else $error("port 1 status zero read mismatch");

    // Port 2 status zero sits at its own offset and returns its own port
    read_p2s0_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RQ14]
        req.rd && req.addr == `PLSR_P2_STAT0_OFS |=> rdata == $past(ph2_q))
        else $error("port 2 status zero read mismatch");

    // Partner pause capability lands in its own bit
    pause_p2_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RQ2]
        req.rd && req.addr == `PLSR_P2_STAT0_OFS |=> rdata[`PLSR_S0_PAUSE_BIT] == $past(ph2_q.partner_pause))
        else $error("partner pause bit mismatch");

    // Partner abilities keep their documented order in the low nibble
    ability_p1_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RQ3]
        req.rd && req.addr == `PLSR_P1_STAT0_OFS |=> rdata[`PLSR_S0_ABIL_MSB:`PLSR_S0_ABIL_LSB] ==
        $past({ph1_q.partner_100fd, ph1_q.partner_100hd, ph1_q.partner_10fd, ph1_q.partner_10hd}))
        else $error("partner ability bits mismatch");

    // The third port's status zero slot carries nothing
    rsvd_zero_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RQ4]
        req.rd && req.addr == `PLSR_P3_STAT0_OFS |=> rdata == `PLSR_ZERO_BYTE)
        else $error("port 3 status zero slot not zero");

    // Reserved bit of every status one word reads zero
    bit6_zero_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RQ7]
        rvalid |-> !(rdata[`PLSR_S1_RSVD_BIT] && $past(is_stat1_ofs(req.addr))))
        else $error("reserved bit 6 read as one");

    // Port 1 status one shows its own algorithm select
    p1_algo_rd_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RQ5]
        req.rd && req.addr == `PLSR_P1_STAT1_OFS |=> rdata[`PLSR_S1_ALGO_BIT] == $past(algo_q[0]))
        else $error("port 1 algorithm select read mismatch");

    // Port 2 status one shows its own algorithm select
    p2_algo_rd_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RQ6]
        req.rd && req.addr == `PLSR_P2_STAT1_OFS |=> rdata[`PLSR_S1_ALGO_BIT] == $past(algo_q[1]))
        else $error("port 2 algorithm select read mismatch");

    // The third port has no crossover, so its select bit reads zero
    p3_algo_zero_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RQ6]
        req.rd && req.addr == `PLSR_P3_STAT1_OFS |=> !rdata[`PLSR_S1_ALGO_BIT])
        else $error("port 3 algorithm select not zero");

    // No polarity report on the third port
    pol_p3_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RQ8]
        req.rd && req.addr == `PLSR_P3_STAT1_OFS |=> !rdata[`PLSR_S1_POL_BIT])
        else $error("polarity reported on port 3");

    // Polarity is hidden at 100 Mb/s
    pol_fast_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RQ8]
        req.rd && req.addr == `PLSR_P1_STAT1_OFS && ln1_q.speed_100 |=> !rdata[`PLSR_S1_POL_BIT])
        else $error("polarity reported at 100 Mb/s");

    // Polarity passes through at 10 Mb/s
    pol_slow_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RQ8]
        req.rd && req.addr == `PLSR_P2_STAT1_OFS && !ln2_q.speed_100 |=>
        rdata[`PLSR_S1_POL_BIT] == $past(ln2_q.pol_reversed))
        else $error("polarity lost at 10 Mb/s");

    // Transmit pause activity
    txp_p1_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RQ9]
        req.rd && req.addr == `PLSR_P1_STAT1_OFS |=> rdata[`PLSR_S1_TXP_BIT] == $past(ln1_q.tx_pause_active))
        else $error("transmit pause bit mismatch");

    // Receive pause activity
    rxp_p2_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RQ10]
        req.rd && req.addr == `PLSR_P2_STAT1_OFS |=> rdata[`PLSR_S1_RXP_BIT] == $past(ln2_q.rx_pause_active))
        else $error("receive pause bit mismatch");

    // Resolved speed
    speed_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RQ11]
        req.rd && req.addr == `PLSR_P3_STAT1_OFS |=> rdata[`PLSR_S1_SPD_BIT] == $past(ln3_q.speed_100))
        else $error("speed bit mismatch");

    // Resolved duplex
    duplex_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RQ12]
        req.rd && req.addr == `PLSR_P2_STAT1_OFS |=> rdata[`PLSR_S1_DUP_BIT] == $past(ln2_q.duplex_full))
        else $error("duplex bit mismatch");

    // Far-end fault passes through on the first port
    fef_p1_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RQ13]
        req.rd && req.addr == `PLSR_P1_STAT1_OFS |=> rdata[`PLSR_S1_FEF_BIT] == $past(ln1_q.far_end_fault))
        else $error("far-end fault lost on port 1");

    // Far-end fault never shows on the second port
    fef_p2_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RQ13]
        req.rd && req.addr == `PLSR_P2_STAT1_OFS |=> !rdata[`PLSR_S1_FEF_BIT])
        else $error("far-end fault reported on port 2");

    // Far-end fault never shows on the third port
    fef_p3_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RQ13]
        req.rd && req.addr == `PLSR_P3_STAT1_OFS |=> !rdata[`PLSR_S1_FEF_BIT])
        else $error("far-end fault reported on port 3");

    // A write to port 1 status one stores its select bit
    algo_wr_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RQ6]
        req.wr && req.addr == `PLSR_P1_STAT1_OFS |=> algo_q[0] == $past(req.wdata[`PLSR_S1_ALGO_BIT]))
        else $error("algorithm select write lost");

    // A write to port 2 status one stores its select bit
    algo_wr2_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RQ6]
        req.wr && req.addr == `PLSR_P2_STAT1_OFS |=> algo_q[1] == $past(req.wdata[`PLSR_S1_ALGO_BIT]))
        else $error("port 2 algorithm select write lost");

    // Nothing but a select write moves the select bits
    algo_hold_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RQ15]
        !(req.wr && is_algo_ofs(req.addr)) |=> $stable(algo_q))
        else $error("algorithm select changed without write");

    // A write to the third port's status one changes nothing
    p3_wr_ignored_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RQ6]
        req.wr && req.addr == `PLSR_P3_STAT1_OFS |=> $stable(algo_q))
        else $error("port 3 write changed algorithm select");

    // Right after reset both ports select the first algorithm
    algo_reset_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RQ6]
        $rose(resetn) |-> algo_q == {2{`PLSR_ALGO_RESET}})
        else $error("algorithm select default wrong");

    // Offsets outside the bank read as zero
    unmapped_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RQ15]
        req.rd && !is_mapped_ofs(req.addr) |=> rdata == `PLSR_ZERO_BYTE)
        else $error("unmapped offset read nonzero");

    // Read data holds between reads
    rdata_hold_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RQ15]
        !req.rd |=> $stable(rdata))
        else $error("read data moved without a read");

    // One answer for each read, one cycle later
    rvalid_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RQ5]
        req.rd |=> rvalid ##1 (rvalid == $past(req.rd)))
        else $error("read answer timing wrong");

    // No answer without a read
    rvalid_idle_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RQ15]
        !req.rd |=> !rvalid)
        else $error("read answer without a read");

    // Transceiver state is followed every cycle once out of reset
    phy_track_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RQ15]
        $past(resetn) |-> ph1_q == $past(phy1_stat) && ph2_q == $past(phy2_stat))
        else $error("transceiver state not tracked");

    // Link state is followed every cycle once out of reset
    link_track_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RQ15]
        $past(resetn) |-> ln1_q == $past(link1_stat) && ln2_q == $past(link2_stat) && ln3_q == $past(link3_stat))
        else $error("link state not tracked");
endmodule
`default_nettype wire

// File: src/plsr_regs.svh
// Register offsets, bit positions and reset values of the port link status bank
`ifndef PLSR_REGS_SVH
`define PLSR_REGS_SVH
`define PLSR_P1_STAT0_OFS 8'h1E
`define PLSR_P2_STAT0_OFS 8'h2E
`define PLSR_P3_STAT0_OFS 8'h3E
`define PLSR_P1_STAT1_OFS 8'h1F
`define PLSR_P2_STAT1_OFS 8'h2F
`define PLSR_P3_STAT1_OFS 8'h3F
`define PLSR_S1_ALGO_BIT 7
`define PLSR_S1_RSVD_BIT 6
`define PLSR_S1_POL_BIT 5
`define PLSR_S1_TXP_BIT 4
`define PLSR_S1_RXP_BIT 3
`define PLSR_S1_SPD_BIT 2
`define PLSR_S1_DUP_BIT 1
`define PLSR_S1_FEF_BIT 0
`define PLSR_S0_PAUSE_BIT 4
`define PLSR_S0_ABIL_MSB 3
`define PLSR_S0_ABIL_LSB 0
`define PLSR_RSVD_VALUE 1'b0
`define PLSR_ALGO_RESET 1'b1
`define PLSR_ZERO_BYTE 8'h00
`endif

// File: src/plsr_pkg.sv
// Types shared by the port link status bank
package plsr_pkg;
    // Live state reported by one transceiver port
    typedef struct packed {
        logic crossover_state;
        logic negotiation_complete;
        logic link_good;
        logic partner_pause;
        logic partner_100fd;
        logic partner_100hd;
        logic partner_10fd;
        logic partner_10hd;
    } plsr_phy_stat_t;
    // Resolved link state reported by every port
    typedef struct packed {
        logic pol_reversed;
        logic tx_pause_active;
        logic rx_pause_active;
        logic speed_100;
        logic duplex_full;
        logic far_end_fault;
    } plsr_link_stat_t;
    // Register access request
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } plsr_req_t;
endpackage

// File: dv/test_port_link_status_registers.sv
// Self-checking testbench for the port link status register bank
`timescale 1ns/1ps
`default_nettype none
module test_port_link_status_registers;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    plsr_pkg::plsr_req_t req = '0;
    plsr_pkg::plsr_phy_stat_t phy1_stat = '0;
    plsr_pkg::plsr_phy_stat_t phy2_stat = '0;
    plsr_pkg::plsr_link_stat_t link1_stat = '0;
    plsr_pkg::plsr_link_stat_t link2_stat = '0;
    plsr_pkg::plsr_link_stat_t link3_stat = '0;
    logic [7:0] rdata;
    logic rvalid;
    logic [1:0] crossover_algo_select;
    int errors = 0;
    int total_checks = 0;

    plsr_bank dut (.core_clk(core_clk), .resetn(resetn), .req(req), .rdata(rdata), .rvalid(rvalid),
        .phy1_stat(phy1_stat), .phy2_stat(phy2_stat), .link1_stat(link1_stat), .link2_stat(link2_stat),
        .link3_stat(link3_stat), .crossover_algo_select(crossover_algo_select));

    // ==========================================
    // Clock, watchdog and shared tasks
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    // Whole run is well under 200 cycles, so this only trips on a hang
    initial begin
        #20000;
        errors++;
        finish_test();
    end
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Read answer lands one edge after the request, so look just past that edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        req <= '{1'b1, 1'b0, a, 8'h00};
        @(posedge core_clk);
        req.rd <= 1'b0;
        #1;
        chk("rvalid", {7'h00, rvalid}, 8'h01);
        chk($sformatf("rdata at %h", a), rdata, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        req <= '{1'b0, 1'b1, a, d};
        @(posedge core_clk);
        req.wr <= 1'b0;
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ==========================================
    // Test sequence
    initial begin
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        rd(8'h1E, 8'h00);
        rd(8'h2E, 8'h00);
        rd(8'h3E, 8'h00);
        rd(8'h1F, 8'h80);
        rd(8'h2F, 8'h80);
        rd(8'h3F, 8'h00);
        chk("algo select", {6'h00, crossover_algo_select}, 8'h03);
        $display("test reset values done");
        // Live status, polarity masked at 100 Mb/s and on the third port
        @(posedge core_clk);
        phy1_stat <= 8'hA5;
        phy2_stat <= 8'h5A;
        link1_stat <= 6'b111111;
        link2_stat <= 6'b100001;
        link3_stat <= 6'b111111;
        rd(8'h1E, 8'hA5);
        rd(8'h2E, 8'h5A);
        rd(8'h3E, 8'h00);
        rd(8'h1F, 8'h9F);
        rd(8'h2F, 8'hA0);
        rd(8'h3F, 8'h1E);
        @(posedge core_clk);
        link1_stat <= 6'b101010;
        rd(8'h1F, 8'hAA);
        @(posedge core_clk);
        link1_stat <= 6'b010101;
        rd(8'h1F, 8'h95);
        @(posedge core_clk);
        link2_stat <= 6'b000011;
        rd(8'h2F, 8'h82);
        $display("test live status done");
        // Writes: only bit 7 of the first two status-one words sticks
        @(posedge core_clk);
        link1_stat <= '0;
        link2_stat <= '0;
        link3_stat <= '0;
        wr(8'h1F, 8'h00);
        rd(8'h1F, 8'h00);
        chk("algo select", {6'h00, crossover_algo_select}, 8'h02);
        wr(8'h2F, 8'h7F);
        rd(8'h2F, 8'h00);
        wr(8'h3F, 8'hFF);
        rd(8'h3F, 8'h00);
        wr(8'h1E, 8'hFF);
        rd(8'h1E, 8'hA5);
        wr(8'h1F, 8'hFF);
        rd(8'h1F, 8'h80);
        chk("algo select", {6'h00, crossover_algo_select}, 8'h01);
        rd(8'h40, 8'h00);
        $display("test writes done");
        // Reset in mid-run restores the select default and clears the read data
        @(posedge core_clk);
        link1_stat <= 6'b011110;
        resetn <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        chk("algo select in reset", {6'h00, crossover_algo_select}, 8'h03);
        chk("rdata in reset", rdata, 8'h00);
        @(posedge core_clk);
        resetn <= 1'b1;
        rd(8'h1F, 8'h9E);
        rd(8'h1E, 8'hA5);
        $display("test mid-run reset done");
        finish_test();
    end
endmodule
`default_nettype wire
